/* File: logic/tlb_test_pkg.sv */
// constants and helpers shared by the translation buffer test access logic
package tlb_test_pkg;
  localparam int NUM_WAYS = 4;
  localparam int NUM_SETS = 8;
  localparam int NUM_ENTRIES = 32;
  localparam int WAY_W = 2;
  localparam int SET_W = 3;
  localparam int IDX_W = 5;
  localparam int TAG_W = 17;
  localparam int PAGE_W = 20;
  localparam int LRU_W = 3;
  // command register fields
  localparam int CMD_LIN_LSB = 12;
  localparam int CMD_V_BIT = 11;
  localparam int CMD_D_BIT = 10;
  localparam int CMD_DN_BIT = 9;
  localparam int CMD_U_BIT = 8;
  localparam int CMD_UN_BIT = 7;
  localparam int CMD_W_BIT = 6;
  localparam int CMD_WN_BIT = 5;
  localparam int CMD_OP_BIT = 0;
  localparam logic OP_WRITE = 1'b0;
  localparam logic OP_LOOKUP = 1'b1;
  // data register fields
  localparam int DATA_PAGE_LSB = 12;
  localparam int DATA_PCD_BIT = 11;
  localparam int DATA_PWT_BIT = 10;
  localparam int DATA_LRU_LSB = 7;
  localparam int DATA_HIT_BIT = 4;
  localparam int DATA_WAY_LSB = 2;
  // register select and reset values
  localparam logic SEL_COMMAND = 1'b0;
  localparam logic SEL_DATA = 1'b1;
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [2:0] LRU_RESET = 3'h0;

  // bit 0 picks the half, bits 1 and 2 the way inside each half
  function automatic logic [1:0] plru_victim(input logic [2:0] s);
    if (!s[0]) begin
      plru_victim = s[1] ? 2'h1 : 2'h0;
    end else begin
      plru_victim = s[2] ? 2'h3 : 2'h2;
    end
  endfunction : plru_victim

  function automatic logic [2:0] plru_touch(input logic [2:0] s, input logic [1:0] way);
    plru_touch = s;
    case (way)
      2'h0: begin
        plru_touch[0] = 1'b1;
        plru_touch[1] = 1'b1;
      end
      2'h1: begin
        plru_touch[0] = 1'b1;
        plru_touch[1] = 1'b0;
      end
      2'h2: begin
        plru_touch[0] = 1'b0;
        plru_touch[2] = 1'b1;
      end
      default: begin
        plru_touch[0] = 1'b0;
        plru_touch[2] = 1'b0;
      end
    endcase
  endfunction : plru_touch
endpackage : tlb_test_pkg

/* File: logic/tlb_plru_state.sv */
// per-set pseudo-lru state of the translation buffer
`timescale 1ns/100ps
module tlb_plru_state import tlb_test_pkg::*; #(
  parameter int SETS = NUM_SETS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SET_W-1:0] rd_set,
  input wire logic touch,
  input wire logic [SET_W-1:0] touch_set,
  input wire logic [WAY_W-1:0] touch_way,
  output logic [LRU_W-1:0] rd_state,
  output logic [SETS*LRU_W-1:0] all_state
);
  // the set index is fixed at SET_W bits, so any other count cannot be addressed
  if (SETS != (1 << SET_W)) begin : g_bad_sets
    $error("set count must match the set index width");
  end

  logic [LRU_W-1:0] lru_q [SETS];
  logic [LRU_W-1:0] lru_d [SETS];

  always_comb begin
    for (int s = 0; s < SETS; s++) begin
      lru_d[s] = lru_q[s];
    end
    if (touch) begin
      lru_d[touch_set] = plru_touch(lru_q[touch_set], touch_way);
    end
  end

  always_ff @(posedge clk) begin
    for (int s = 0; s < SETS; s++) begin
      lru_q[s] <= rst ? LRU_RESET : lru_d[s];
    end
  end

  assign rd_state = lru_q[rd_set];

  genvar g;
  generate
    for (g = 0; g < SETS; g++) begin : g_flat
      assign all_state[g*LRU_W +: LRU_W] = lru_q[g];
    end
  endgenerate
endmodule : tlb_plru_state

/* File: logic/tlb_test_access.sv */
// translation buffer arrays with command and data test register access
//
// Behaviour
// RULE_01: four ways, eight sets, 32 entries
// RULE_02: data entry: 20-bit page plus two attributes
// RULE_03: tag entry: 17-bit tag plus four protection bits
// RULE_04: three-bit pseudo-lru per set, cache algorithm
// RULE_05: command: address 31:12, protection 11:5, op bit0
// RULE_06: low three address bits pick set, rest tag
// RULE_07: command write launches: 0 write, 1 lookup
// RULE_08: write pairs: 01 stores 0, 10 stores 1
// RULE_09: lookup pairs: 00 miss, 01/10 match, 11 any
// RULE_10: data: page 31:12, attributes 11:10, lru 9:7
// RULE_11: write way: bit4 0 lru, 1 bits 3:2
// RULE_12: every entry write makes it most recent
// RULE_13: software loads data register before command register
// RULE_14: lru field ignored on test write
// RULE_15: lookup result in data bit4, 1 hit
// RULE_16: hit returns way, page and attributes
// RULE_17: returned lru is state before lookup
// RULE_18: miss leaves other data bits undefined
// RULE_19: test lookup hit makes entry most recent
// RULE_20: duplicate tags in a set never hit
// RULE_21: software avoids writing one address twice per set
// RULE_22: test works alongside normal translation traffic
// RULE_23: lookup result latched before next register read
`timescale 1ns/100ps
module tlb_test_access import tlb_test_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_wr_sel,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] command_rdata,
  output logic [31:0] data_rdata,
  input wire logic xl_req,
  input wire logic [PAGE_W-1:0] xl_linear,
  output logic xl_ready,
  output logic xl_done,
  output logic xl_hit,
  output logic [PAGE_W-1:0] xl_page,
  output logic xl_pcd,
  output logic xl_pwt,
  output logic [2:0] xl_prot,
  input wire logic fill_req,
  input wire logic [PAGE_W-1:0] fill_linear,
  input wire logic [PAGE_W-1:0] fill_page,
  input wire logic fill_pcd,
  input wire logic fill_pwt,
  input wire logic fill_dirty,
  input wire logic fill_user,
  input wire logic fill_rw,
  output logic fill_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // entry storage, index is {set, way}
  logic [TAG_W-1:0] tag_q [NUM_ENTRIES];
  logic [TAG_W-1:0] tag_d [NUM_ENTRIES];
  logic [PAGE_W-1:0] page_q [NUM_ENTRIES];
  logic [PAGE_W-1:0] page_d [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] valid_q, valid_d, dirty_q, dirty_d, user_q, user_d, rw_q, rw_d, pcd_q, pcd_d, pwt_q, pwt_d;
  logic [31:0] command_q, command_d, data_q, data_d;
  logic xl_done_q, xl_done_d, xl_hit_q, xl_hit_d, xl_pcd_q, xl_pcd_d, xl_pwt_q, xl_pwt_d;
  logic [PAGE_W-1:0] xl_page_q, xl_page_d;
  logic [2:0] xl_prot_q, xl_prot_d;

  logic test_op, test_wr, test_look, do_fill, do_xl;
  logic [PAGE_W-1:0] op_linear;
  logic [SET_W-1:0] op_set;
  logic [TAG_W-1:0] op_tag;
  logic [NUM_WAYS-1:0] way_match, set_valid;
  logic [2:0] match_cnt;
  logic uniq_hit, forced_miss;
  logic [WAY_W-1:0] hit_way, victim_way, wr_way;
  logic [IDX_W-1:0] hit_idx, wr_idx;
  logic [LRU_W-1:0] set_lru;
  logic [NUM_SETS*LRU_W-1:0] lru_all;
  logic lru_touch;
  logic [WAY_W-1:0] touch_way;

  // pair match: true bit allows stored 1, complement allows stored 0
  function automatic logic pair_ok(input logic b, input logic bn, input logic stored);
    pair_ok = (b & stored) | (bn & ~stored);
  endfunction : pair_ok

  // a command write is the only trigger, so data must already hold the fill values
  assign test_op = reg_wr && (reg_wr_sel == SEL_COMMAND); // RULE_07 RULE_13
  assign test_wr = test_op && (reg_wdata[CMD_OP_BIT] == OP_WRITE); // RULE_07
  assign test_look = test_op && (reg_wdata[CMD_OP_BIT] == OP_LOOKUP); // RULE_07
  // test traffic takes the arrays first; normal traffic stalls one cycle, paging stays on
  assign fill_ready = !test_op; // RULE_22
  assign xl_ready = !test_op && !fill_req; // RULE_22
  assign do_fill = fill_req && fill_ready;
  assign do_xl = xl_req && xl_ready;

  always_comb begin
    if (test_op) begin
      op_linear = reg_wdata[31:CMD_LIN_LSB]; // RULE_05
    end else if (fill_req) begin
      op_linear = fill_linear;
    end else begin
      op_linear = xl_linear;
    end
  end
  assign op_set = op_linear[SET_W-1:0]; // RULE_06
  assign op_tag = op_linear[PAGE_W-1:SET_W]; // RULE_06

  // per-way compare; protection pairs only constrain test lookups
  genvar g;
  generate
    for (g = 0; g < NUM_WAYS; g++) begin : g_way
      logic [IDX_W-1:0] ix;
      logic prot_ok;
      assign ix = {op_set, WAY_W'(g)};
      assign set_valid[g] = valid_q[ix];
      assign prot_ok = !test_look || (reg_wdata[CMD_V_BIT]
        && pair_ok(reg_wdata[CMD_D_BIT], reg_wdata[CMD_DN_BIT], dirty_q[ix])
        && pair_ok(reg_wdata[CMD_U_BIT], reg_wdata[CMD_UN_BIT], user_q[ix])
        && pair_ok(reg_wdata[CMD_W_BIT], reg_wdata[CMD_WN_BIT], rw_q[ix])); // RULE_09
      assign way_match[g] = valid_q[ix] && (tag_q[ix] == op_tag) && prot_ok; // RULE_01
    end
  endgenerate

  assign forced_miss = test_look && (!reg_wdata[CMD_V_BIT]
    || (reg_wdata[CMD_D_BIT] == 1'b0 && reg_wdata[CMD_DN_BIT] == 1'b0)
    || (reg_wdata[CMD_U_BIT] == 1'b0 && reg_wdata[CMD_UN_BIT] == 1'b0)
    || (reg_wdata[CMD_W_BIT] == 1'b0 && reg_wdata[CMD_WN_BIT] == 1'b0));

  always_comb begin
    match_cnt = 3'h0;
    hit_way = 2'h0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      if (way_match[w]) begin
        match_cnt = match_cnt + 3'h1;
        hit_way = WAY_W'(w);
      end
    end
  end
  // two copies of a tag in one set cannot be told apart, so neither hits
  assign uniq_hit = (match_cnt == 3'h1); // RULE_20
  assign hit_idx = {op_set, hit_way};

  // empty ways fill before the pseudo-lru pointer is consulted
  always_comb begin
    victim_way = plru_victim(set_lru); // RULE_04
    for (int w = NUM_WAYS - 1; w >= 0; w--) begin
      if (!set_valid[w]) begin
        victim_way = WAY_W'(w);
      end
    end
  end
  assign wr_way = (test_wr && data_q[DATA_HIT_BIT]) ? data_q[DATA_WAY_LSB +: WAY_W] : victim_way; // RULE_11
  assign wr_idx = {op_set, wr_way};

  always_comb begin
    lru_touch = 1'b0;
    touch_way = hit_way;
    if (test_wr || do_fill) begin
      lru_touch = 1'b1; // RULE_12
      touch_way = wr_way; // RULE_12
    end else if ((test_look || do_xl) && uniq_hit) begin
      lru_touch = 1'b1; // RULE_19
    end
  end

  tlb_plru_state #(
    .SETS(NUM_SETS)
  ) u_plru (
    .clk(clk),
    .rst(rst),
    .rd_set(op_set),
    .touch(lru_touch),
    .touch_set(op_set),
    .touch_way(touch_way),
    .rd_state(set_lru),
    .all_state(lru_all)
  );

  // entry array next state
  always_comb begin
    tag_d = tag_q;
    page_d = page_q;
    valid_d = valid_q;
    dirty_d = dirty_q;
    user_d = user_q;
    rw_d = rw_q;
    pcd_d = pcd_q;
    pwt_d = pwt_q;
    if (test_wr) begin
      tag_d[wr_idx] = op_tag; // RULE_03 RULE_06
      page_d[wr_idx] = data_q[31:DATA_PAGE_LSB]; // RULE_02
      pcd_d[wr_idx] = data_q[DATA_PCD_BIT]; // RULE_02
      pwt_d[wr_idx] = data_q[DATA_PWT_BIT]; // RULE_02
      // undefined pairs 00 and 11 simply store the true bit
      valid_d[wr_idx] = reg_wdata[CMD_V_BIT]; // RULE_03
      dirty_d[wr_idx] = reg_wdata[CMD_D_BIT]; // RULE_08
      user_d[wr_idx] = reg_wdata[CMD_U_BIT]; // RULE_08
      rw_d[wr_idx] = reg_wdata[CMD_W_BIT]; // RULE_08
    end else if (do_fill) begin
      tag_d[wr_idx] = op_tag;
      page_d[wr_idx] = fill_page;
      pcd_d[wr_idx] = fill_pcd;
      pwt_d[wr_idx] = fill_pwt;
      valid_d[wr_idx] = 1'b1;
      dirty_d[wr_idx] = fill_dirty;
      user_d[wr_idx] = fill_user;
      rw_d[wr_idx] = fill_rw;
    end
  end

  always_ff @(posedge clk) begin
    tag_q <= tag_d;
    page_q <= page_d;
    pcd_q <= pcd_d;
    pwt_q <= pwt_d;
    dirty_q <= dirty_d;
    user_q <= user_d;
    rw_q <= rw_d;
    valid_q <= rst ? '0 : valid_d;
  end

  // test registers and normal lookup results
  always_comb begin
    command_d = command_q;
    data_d = data_q;
    if (test_op) begin
      command_d = reg_wdata; // RULE_05
    end else if (reg_wr) begin
      data_d = reg_wdata; // RULE_10
    end
    // result lands on the launching edge, so the very next read sees it
    if (test_look) begin
      data_d[DATA_HIT_BIT] = uniq_hit; // RULE_15 RULE_23
      if (uniq_hit) begin // RULE_18
        data_d[31:DATA_PAGE_LSB] = page_q[hit_idx]; // RULE_16
        data_d[DATA_PCD_BIT] = pcd_q[hit_idx]; // RULE_16
        data_d[DATA_PWT_BIT] = pwt_q[hit_idx]; // RULE_16
        data_d[DATA_LRU_LSB +: LRU_W] = set_lru; // RULE_17
        data_d[DATA_WAY_LSB +: WAY_W] = hit_way; // RULE_16
      end
      // on a miss the remaining bits keep their old contents
    end
    xl_done_d = do_xl;
    xl_hit_d = do_xl && uniq_hit;
    xl_page_d = page_q[hit_idx];
    xl_pcd_d = pcd_q[hit_idx];
    xl_pwt_d = pwt_q[hit_idx];
    xl_prot_d = {dirty_q[hit_idx], user_q[hit_idx], rw_q[hit_idx]};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      command_q <= COMMAND_RESET;
      data_q <= DATA_RESET;
      xl_done_q <= 1'b0;
      xl_hit_q <= 1'b0;
      xl_page_q <= '0;
      xl_pcd_q <= 1'b0;
      xl_pwt_q <= 1'b0;
      xl_prot_q <= 3'h0;
    end else begin
      command_q <= command_d;
      data_q <= data_d;
      xl_done_q <= xl_done_d;
      xl_hit_q <= xl_hit_d;
      xl_page_q <= xl_page_d;
      xl_pcd_q <= xl_pcd_d;
      xl_pwt_q <= xl_pwt_d;
      xl_prot_q <= xl_prot_d;
    end
  end

  assign command_rdata = command_q;
  assign data_rdata = data_q;
  assign xl_done = xl_done_q;
  assign xl_hit = xl_hit_q;
  assign xl_page = xl_page_q;
  assign xl_pcd = xl_pcd_q;
  assign xl_pwt = xl_pwt_q;
  assign xl_prot = xl_prot_q;

  a_lookup_hit_flag: assert property (test_look |=> data_q[DATA_HIT_BIT] == $past(uniq_hit)) // RULE_15
    else $error("lookup hit flag wrong");
  a_hit_way_page: assert property (test_look && uniq_hit |=> data_q[DATA_WAY_LSB +: WAY_W] == $past(hit_way)
    && data_q[31:DATA_PAGE_LSB] == page_q[$past(hit_idx)]) // RULE_16
    else $error("hit way or page wrong");
  a_lru_prior_value: assert property (test_look && uniq_hit
    |=> data_q[DATA_LRU_LSB +: LRU_W] == $past(set_lru)) // RULE_17
    else $error("returned lru is not the prior state");
  a_hit_makes_mru: assert property (test_look && uniq_hit
    |=> lru_all[$past(op_set)*LRU_W +: LRU_W] == plru_touch($past(set_lru), $past(hit_way))) // RULE_19
    else $error("lookup hit did not update lru");
  a_write_makes_mru: assert property (test_wr
    |=> lru_all[$past(op_set)*LRU_W +: LRU_W] == plru_touch($past(set_lru), $past(wr_way))) // RULE_12
    else $error("write did not make entry most recent");
  a_dup_no_hit: assert property (test_look && match_cnt > 3'h1 |=> !data_q[DATA_HIT_BIT]) // RULE_20
    else $error("duplicate tag reported a hit");
  a_forced_pair_miss: assert property (forced_miss |=> !data_q[DATA_HIT_BIT]) // RULE_09
    else $error("forced miss pattern hit");
  a_write_stores_entry: assert property (test_wr |=> tag_q[$past(wr_idx)] == $past(op_tag)
    && page_q[$past(wr_idx)] == $past(data_q[31:DATA_PAGE_LSB])) // RULE_06
    else $error("test write stored wrong tag or page");
  a_pointer_from_data: assert property (test_wr && data_q[DATA_HIT_BIT]
    |=> tag_q[{$past(op_set), $past(data_q[DATA_WAY_LSB +: WAY_W])}] == $past(op_tag)) // RULE_11
    else $error("explicit way pointer not used");
  a_pair_stores_bit: assert property (test_wr && reg_wdata[CMD_D_BIT] && !reg_wdata[CMD_DN_BIT]
    |=> dirty_q[$past(wr_idx)]) // RULE_08
    else $error("pair 10 did not store 1");
  a_write_keeps_data: assert property (test_wr |=> data_q == $past(data_q)) // RULE_14
    else $error("test write changed the data register");
endmodule : tlb_test_access

/* File: test/tb_top.sv */
// self-checking bench for the translation buffer test access logic
`timescale 1ns/100ps
module tb_top import tlb_test_pkg::*;;
  typedef struct packed {
    logic op;
    logic [19:0] lin;
    logic [6:0] prot;
    logic [31:0] dw;
    logic [31:0] exp;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_wr_sel = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic xl_req = 1'b0;
  logic [PAGE_W-1:0] xl_linear = 20'h0;
  logic fill_req = 1'b0;
  logic [PAGE_W-1:0] fill_linear = 20'h0;
  logic [PAGE_W-1:0] fill_page = 20'h0;
  logic fill_pcd = 1'b0;
  logic fill_pwt = 1'b0;
  logic fill_dirty = 1'b0;
  logic fill_user = 1'b0;
  logic fill_rw = 1'b0;
  logic [31:0] command_rdata;
  logic [31:0] data_rdata;
  logic xl_ready;
  logic xl_done;
  logic xl_hit;
  logic [PAGE_W-1:0] xl_page;
  logic xl_pcd;
  logic xl_pwt;
  logic [2:0] xl_prot;
  logic fill_ready;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  row_s rows[$];
  logic [31:0] msk;

  tlb_test_access i_tlb_test_access (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
    .reg_wdata(reg_wdata), .command_rdata(command_rdata), .data_rdata(data_rdata), .xl_req(xl_req),
    .xl_linear(xl_linear), .xl_ready(xl_ready), .xl_done(xl_done), .xl_hit(xl_hit), .xl_page(xl_page),
    .xl_pcd(xl_pcd), .xl_pwt(xl_pwt), .xl_prot(xl_prot), .fill_req(fill_req), .fill_linear(fill_linear),
    .fill_page(fill_page), .fill_pcd(fill_pcd), .fill_pwt(fill_pwt), .fill_dirty(fill_dirty),
    .fill_user(fill_user), .fill_rw(fill_rw), .fill_ready(fill_ready));

  always #2.5 clk = ~clk;

  // run should need about 120 cycles; far above that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  function automatic logic [31:0] dat(logic [19:0] pg, logic [1:0] attr, logic [2:0] lru, logic h, logic [1:0] w);
    dat = {pg, attr, lru, 2'h0, h, w, 2'h0};
  endfunction : dat

  function automatic row_s wr(logic [19:0] lin, logic [6:0] prot, logic [31:0] d);
    wr = '{op: OP_WRITE, lin: lin, prot: prot, dw: d, exp: d};
  endfunction : wr

  // lookups preload all ones so a miss must clear the flag
  function automatic row_s lk(logic [19:0] lin, logic [6:0] prot, logic [31:0] e);
    lk = '{op: OP_LOOKUP, lin: lin, prot: prot, dw: 32'hffff_ffff, exp: e};
  endfunction : lk

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m, input string what);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic sel, input logic [31:0] val);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_wr_sel = sel;
    reg_wdata = val;
    #1;
    if (sel == SEL_COMMAND) begin
      chk({30'h0, xl_ready, fill_ready}, 32'h0, 32'h3, "ready during command write");
    end
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    // prot {v, d, dn, u, un, w, wn}: 66 stores d1 u0 w1, 55 all zero, 7f matches anything
    rows = {
      wr(20'h12341, 7'h66, dat(20'habcde, 2'h2, 3'h0, 1'b0, 2'h0)),
      lk(20'h12341, 7'h66, dat(20'habcde, 2'h2, 3'h3, 1'b1, 2'h0)),
      lk(20'h12341, 7'h56, 32'h0),
      lk(20'h12341, 7'h62, 32'h0),
      lk(20'h12341, 7'h7f, dat(20'habcde, 2'h2, 3'h3, 1'b1, 2'h0)),
      lk(20'h12341, 7'h3f, 32'h0),
      lk(20'h12349, 7'h7f, 32'h0),
      wr(20'h55551, 7'h55, dat(20'h13579, 2'h1, 3'h7, 1'b1, 2'h3)),
      lk(20'h55551, 7'h55, dat(20'h13579, 2'h1, 3'h2, 1'b1, 2'h3)),
      lk(20'h55551, 7'h66, 32'h0),
      wr(20'h00011, 7'h55, dat(20'h22222, 2'h0, 3'h5, 1'b0, 2'h2)),
      lk(20'h00011, 7'h7f, dat(20'h22222, 2'h0, 3'h1, 1'b1, 2'h1)),
      wr(20'h00021, 7'h55, dat(20'h33333, 2'h0, 3'h0, 1'b0, 2'h0)),
      wr(20'h00031, 7'h55, dat(20'h44444, 2'h0, 3'h0, 1'b0, 2'h0)),
      lk(20'h12341, 7'h7f, 32'h0),
      lk(20'h00031, 7'h7f, dat(20'h44444, 2'h0, 3'h7, 1'b1, 2'h0)),
      lk(20'h00021, 7'h7f, dat(20'h33333, 2'h0, 3'h7, 1'b1, 2'h2)),
      wr(20'h00021, 7'h55, dat(20'h55555, 2'h0, 3'h0, 1'b1, 2'h0)),
      lk(20'h00021, 7'h7f, 32'h0),
      lk(20'h12346, 7'h7f, 32'h0),
      wr(20'h12346, 7'h66, dat(20'h0f0f0, 2'h3, 3'h0, 1'b0, 2'h0)),
      lk(20'h12346, 7'h66, dat(20'h0f0f0, 2'h3, 3'h3, 1'b1, 2'h0))};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(command_rdata, COMMAND_RESET, 32'hffff_ffff, "command after reset");
    chk(data_rdata, DATA_RESET, 32'hffff_ffff, "data after reset");
    foreach (rows[i]) begin
      reg_write(SEL_DATA, rows[i].dw);
      reg_write(SEL_COMMAND, {rows[i].lin, rows[i].prot, 4'h0, rows[i].op});
      chk(command_rdata, {rows[i].lin, rows[i].prot, 4'h0, rows[i].op}, 32'hffff_ffff, "command");
      // miss leaves only the flag defined; hit bits 6:5 and 1:0 carry nothing
      msk = (rows[i].op == OP_WRITE) ? 32'hffff_ffff : (rows[i].exp[4] ? 32'hffff_ff9c : 32'h10);
      chk(data_rdata, rows[i].exp, msk, "data row");
    end
    $display("table test done");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(data_rdata, DATA_RESET, 32'hffff_ffff, "data after second reset");
    chk({31'h0, xl_done}, 32'h0, 32'h1, "done idle after reset");
    reg_write(SEL_DATA, 32'hffff_ffff);
    reg_write(SEL_COMMAND, {20'h00031, 7'h7f, 4'h0, OP_LOOKUP});
    chk(data_rdata, 32'h0, 32'h10, "entries invalid after reset");
    $display("reset test done");
    @(negedge clk);
    fill_req = 1'b1;
    fill_linear = 20'h0abc5;
    fill_page = 20'h77777;
    fill_pcd = 1'b1;
    fill_pwt = 1'b1;
    fill_dirty = 1'b1;
    fill_user = 1'b0;
    fill_rw = 1'b1;
    #1;
    chk({30'h0, xl_ready, fill_ready}, 32'h1, 32'h3, "fill ready, translation held off");
    @(negedge clk);
    fill_req = 1'b0;
    // normal fill must land in way 0 and mark it most recent
    reg_write(SEL_DATA, 32'hffff_ffff);
    reg_write(SEL_COMMAND, {20'h0abc5, 7'h66, 4'h0, OP_LOOKUP});
    chk(data_rdata, dat(20'h77777, 2'h3, 3'h3, 1'b1, 2'h0), 32'hffff_ff9c, "lookup of fill");
    @(negedge clk);
    xl_req = 1'b1;
    xl_linear = 20'h0abc5;
    @(negedge clk);
    xl_req = 1'b0;
    chk({5'h0, xl_done, xl_hit, xl_pcd, xl_pwt, xl_prot, xl_page}, {5'h0, 4'hf, 3'h5, 20'h77777},
      32'hffff_ffff, "translation hit");
    @(negedge clk);
    xl_req = 1'b1;
    xl_linear = 20'h0abcd;
    @(negedge clk);
    xl_req = 1'b0;
    chk({30'h0, xl_done, xl_hit}, 32'h2, 32'h3, "translation miss");
    @(negedge clk);
    chk({31'h0, xl_done}, 32'h0, 32'h1, "done is a one-cycle pulse");
    $display("normal traffic test done");
    test_done();
  end
endmodule : tb_top
